// ---- design/short_fault_readout.sv ----
// Overview of operation
// - Mode low: short flag follows live comparator, no latch, no output disable.
// - Every detected short sets its register bit in either mode, held until clear.
// - Low-side comparator ignored while FET off and one blank time after turn-on.
// - Mode high: qualified short latches second flag and disables all gates.
// - High-side comparator uses same ignore conditions as low-side.
// - High-side over sets high bits, low-side over sets low bits.
// - Primary low, secondary high means short; both high means undervoltage.
// - Ten-bit register accumulates until reset or completed readout.
// - Logic-supply undervoltage clears register, drives both flags high.
// - Shift order high A-C, low A-C, gate supply, boot A-C.
// - Readout only while secondary flag released high.
// - Flags are open drain, released high during faults.
// - First falling clock edge presents phase A high short on primary flag.
// - Each further high-low cycle presents next bit.
// - Falling edge after last bit clears register and flags.
// - Unlatched faults still present show again immediately after clear.
// - Overtemperature drives primary high, secondary low, unlatched.
// - Flags are OR of all present fault flag states.
`include "short_fault_defs.svh"
module short_fault_readout (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic shift_clk,
  input wire logic fault_stop_mode,
  input wire short_fault_pkg::fet_sense_t fet_sense,
  input wire short_fault_pkg::supply_status_t supply,
  input wire logic flag_secondary_in,
  output logic fault_flag_primary_out,
  output logic fault_flag_primary_oe,
  output logic fault_flag_secondary_out,
  output logic fault_flag_secondary_oe,
  output logic gate_disable,
  output logic [9:0] fault_capture_register
);
  import short_fault_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] mode_sync;
  logic [5:0] on_s1, on_s2, over_s1, over_s2;
  logic [5:0] sup_s1, sup_s2;
  always_ff @(posedge clk) begin
    mode_sync <= {mode_sync[0], fault_stop_mode};
    on_s1 <= {fet_sense.low_on, fet_sense.high_on};
    on_s2 <= on_s1;
    over_s1 <= {fet_sense.low_over, fet_sense.high_over};
    over_s2 <= over_s1;
    sup_s1 <= {supply.vreg_uv, supply.vdd_uv, supply.overtemp, supply.boot_uv};
    sup_s2 <= sup_s1;
  end
  wire stop_mode = mode_sync[1];
  wire vreg_uv = sup_s2[5];
  wire vdd_uv = sup_s2[4];
  wire overtemp = sup_s2[3];
  wire [2:0] boot_uv = sup_s2[2:0];

  // ----------------------------------------
  // Shift clock in link domain
  // ----------------------------------------
  // Pin synchronised on link clock; each falling edge toggles a flag
  logic [1:0] link_pin_sync = 2'b11;
  logic link_pin_q = 1'b1;
  logic link_tog = 1'b0;
  always_ff @(posedge shift_clk) begin
    link_pin_sync <= {link_pin_sync[0], flag_secondary_in};
    link_pin_q <= link_pin_sync[1];
    if (link_pin_q && !link_pin_sync[1]) begin
      link_tog <= ~link_tog;
    end
  end
  // No reset here, so a release of reset makes no false edge
  logic [2:0] tog_sync;
  always_ff @(posedge clk) begin
    tog_sync <= {tog_sync[1:0], link_tog};
  end
  wire fall_evt = tog_sync[2] ^ tog_sync[1];

  // ----------------------------------------
  // Blanking per FET
  // ----------------------------------------
  logic [`BLANK_CNT_W-1:0] blank_cnt [6];
  logic [5:0] qual_over;
  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (sys_rst || !on_s2[i]) begin
        blank_cnt[i] <= '0;
      end else if (blank_cnt[i] != `BLANK_CNT_W'(`FAULT_BLANK_CYC)) begin
        blank_cnt[i] <= blank_cnt[i] + 1'b1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      qual_over[i] = on_s2[i] && over_s2[i] &&
        (blank_cnt[i] == `BLANK_CNT_W'(`FAULT_BLANK_CYC));
    end
  end

  // ----------------------------------------
  // Readout sequencer
  // ----------------------------------------
  read_state_t state;
  logic [`SHIFT_CNT_W-1:0] bit_ptr;
  logic read_clear;
  logic short_latch;
  wire sec_released = !fault_flag_secondary_oe;
  always_ff @(posedge clk) begin
    read_clear <= 1'b0;
    if (sys_rst || vdd_uv) begin
      state <= RD_IDLE;
      bit_ptr <= '0;
    end else begin
      case (state)
        RD_IDLE: begin
          if (fall_evt && sec_released) begin
            state <= RD_SHIFT;
            bit_ptr <= '0;
          end
        end
        RD_SHIFT: begin
          if (fall_evt) begin
            if (bit_ptr == `SHIFT_CNT_W'(`SHIFT_LAST - 1)) begin
              state <= RD_DONE;
              read_clear <= 1'b1;
            end else begin
              bit_ptr <= bit_ptr + 1'b1;
            end
          end
        end
        RD_DONE: state <= RD_IDLE;
        default: state <= RD_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Fault capture register
  // ----------------------------------------
  logic [9:0] next_fcr;
  always_comb begin
    next_fcr = fault_capture_register;
    if (read_clear) begin
      next_fcr = `FCR_RESET;
    end
    next_fcr[`FCR_LOW_C:`FCR_HIGH_A] = next_fcr[`FCR_LOW_C:`FCR_HIGH_A] | qual_over;
    next_fcr[`FCR_GATE_UV] = next_fcr[`FCR_GATE_UV] | vreg_uv;
    next_fcr[`FCR_BOOT_C:`FCR_BOOT_A] = next_fcr[`FCR_BOOT_C:`FCR_BOOT_A] | boot_uv;
  end
  always_ff @(posedge clk) begin
    if (sys_rst || vdd_uv) begin
      fault_capture_register <= `FCR_RESET;
    end else begin
      fault_capture_register <= next_fcr; // order by index
    end
  end

  // ----------------------------------------
  // Latched short and bootstrap states
  // ----------------------------------------
  logic boot_latch;
  always_ff @(posedge clk) begin
    if (sys_rst || vdd_uv || read_clear) begin
      short_latch <= 1'b0;
      boot_latch <= 1'b0;
    end else begin
      if (stop_mode && |qual_over) begin
        short_latch <= 1'b1;
      end
      if (|boot_uv) begin
        boot_latch <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Flag and gate outputs
  // ----------------------------------------
  logic next_prim, next_sec;
  always_comb begin
    next_sec = short_latch || (|qual_over) || vreg_uv || boot_latch || vdd_uv;
    next_prim = overtemp || vreg_uv || boot_latch || vdd_uv;
    if (state == RD_SHIFT) begin
      next_sec = 1'b1;
      next_prim = fault_capture_register[bit_ptr];
    end
    if (read_clear) begin
      next_sec = vreg_uv || vdd_uv;
      next_prim = vreg_uv || vdd_uv || overtemp;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_flag_primary_out <= 1'b0;
      fault_flag_primary_oe <= 1'b1;
      fault_flag_secondary_out <= 1'b0;
      fault_flag_secondary_oe <= 1'b1;
      gate_disable <= 1'b1;
    end else begin
      fault_flag_primary_out <= 1'b0;
      fault_flag_primary_oe <= !next_prim;
      fault_flag_secondary_out <= 1'b0;
      fault_flag_secondary_oe <= !next_sec;
      gate_disable <= vdd_uv || vreg_uv || boot_latch ||
        (stop_mode && (short_latch || |qual_over || overtemp));
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  vdd_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    vdd_uv |=> (fault_capture_register == `FCR_RESET && !fault_flag_secondary_oe &&
      !fault_flag_primary_oe))
    else $error("register not cleared in vdd undervoltage");
  short_disable_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stop_mode && |qual_over) |=> gate_disable)
    else $error("short with stop mode did not disable gates");
  short_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (qual_over[0] && !vdd_uv) |=> fault_capture_register[`FCR_HIGH_A])
    else $error("short not captured");
  blank_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
    !on_s2[3] |-> !qual_over[3])
    else $error("comparator not ignored while fet off");
  no_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!stop_mode && !short_latch) |=> !short_latch)
    else $error("latch behaviour wrong");
  overtemp_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    (overtemp && state == RD_IDLE && !vreg_uv && !vdd_uv && !boot_latch && !short_latch
     && !(|qual_over)) |=> (!fault_flag_primary_oe && fault_flag_secondary_oe))
    else $error("overtemperature flags wrong");
  read_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == RD_IDLE && fault_flag_secondary_oe) |=> state == RD_IDLE)
    else $error("readout started while flag held low");
  clear_end_a: assert property (@(posedge clk) disable iff (sys_rst)
    read_clear |-> ##0 $past(bit_ptr) == 4'd9 ##1 fault_capture_register[`FCR_LOW_C:`FCR_HIGH_A] ==
      $past(qual_over))
    else $error("readout clear wrong");
  first_bit_a: assert property (@(posedge clk) disable iff (sys_rst || vdd_uv)
    (state == RD_IDLE && $past(state) == RD_IDLE) ##1 (state == RD_SHIFT) |-> bit_ptr == 4'd0)
    else $error("readout did not start at first bit");

  // ----------------------------------------
  // Flag, bit and gate checks
  // ----------------------------------------
  wire shown_bit = fault_capture_register[bit_ptr];
  shift_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == RD_SHIFT && !read_clear) |=> fault_flag_primary_oe == !$past(shown_bit))
    else $error("serial bit not shown");
  read_start_a: assert property (@(posedge clk) disable iff (sys_rst || vdd_uv)
    (state == RD_IDLE && fall_evt && !fault_flag_secondary_oe) |=> state == RD_SHIFT)
    else $error("readout not started on released flag");
  ptr_range_a: assert property (@(posedge clk) disable iff (sys_rst)
    bit_ptr <= 4'd9)
    else $error("bit pointer out of range");
  open_drain_a: assert property (@(posedge clk) disable iff (sys_rst)
    !fault_flag_primary_out && !fault_flag_secondary_out)
    else $error("flag driven high");
  live_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!stop_mode && !vdd_uv && !vreg_uv && !boot_latch) |=> !gate_disable)
    else $error("gates disabled with stop mode low");
  short_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == RD_IDLE && |qual_over && !overtemp && !vreg_uv && !vdd_uv && !boot_latch)
      |=> (fault_flag_primary_oe && !fault_flag_secondary_oe))
    else $error("short flag pattern wrong");
  uv_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    (vreg_uv && state != RD_SHIFT) |=> (!fault_flag_primary_oe && !fault_flag_secondary_oe))
    else $error("undervoltage flag pattern wrong");
  redisplay_a: assert property (@(posedge clk) disable iff (sys_rst)
    (read_clear && vreg_uv) |=> (!fault_flag_primary_oe && !fault_flag_secondary_oe))
    else $error("unlatched fault not shown after clear");
  latch_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    read_clear |=> (!short_latch && !boot_latch))
    else $error("latched states not cleared by readout");
  ot_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stop_mode && overtemp) |=> gate_disable)
    else $error("overtemperature did not disable gates");
  vdd_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    vdd_uv |=> gate_disable)
    else $error("logic undervoltage did not disable gates");
  high_b_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (qual_over[1] && !vdd_uv) |=> fault_capture_register[`FCR_HIGH_B])
    else $error("high side short b not captured");
  high_c_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (qual_over[2] && !vdd_uv) |=> fault_capture_register[`FCR_HIGH_C])
    else $error("high side short c not captured");
  low_a_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (qual_over[3] && !vdd_uv) |=> fault_capture_register[`FCR_LOW_A])
    else $error("low side short a not captured");
  low_c_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (qual_over[5] && !vdd_uv) |=> fault_capture_register[`FCR_LOW_C])
    else $error("low side short c not captured");
  gate_uv_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (vreg_uv && !vdd_uv) |=> fault_capture_register[`FCR_GATE_UV])
    else $error("gate supply undervoltage not captured");
  boot_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (boot_uv[2] && !vdd_uv) |=> fault_capture_register[`FCR_BOOT_C])
    else $error("bootstrap undervoltage not captured");
endmodule // short_fault_readout

// ---- inc/short_fault_defs.svh ----
`ifndef SHORT_FAULT_DEFS_SVH
`define SHORT_FAULT_DEFS_SVH
// ----------------------------------------
// Fault capture register layout
// ----------------------------------------
`define FCR_WIDTH 10
`define FCR_RESET 10'h000
`define FCR_HIGH_A 0
`define FCR_HIGH_B 1
`define FCR_HIGH_C 2
`define FCR_LOW_A 3
`define FCR_LOW_B 4
`define FCR_LOW_C 5
`define FCR_GATE_UV 6
`define FCR_BOOT_A 7
`define FCR_BOOT_B 8
`define FCR_BOOT_C 9
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define FAULT_BLANK_NS 2000
`define FAULT_BLANK_CYC ((`FAULT_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_CNT_W 7
`define SHIFT_CNT_W 4
`define SHIFT_LAST 4'd10
`endif

// ---- inc/short_fault_pkg.sv ----
package short_fault_pkg;
  typedef struct packed {
    logic [2:0] high_on;
    logic [2:0] low_on;
    logic [2:0] high_over;
    logic [2:0] low_over;
  } fet_sense_t;
  typedef struct packed {
    logic vreg_uv;
    logic vdd_uv;
    logic overtemp;
    logic [2:0] boot_uv;
  } supply_status_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_SHIFT = 2'b01,
    RD_DONE = 2'b10
  } read_state_t;
endpackage

// ---- test/flag_controller.sv ----
// ----------------------------------------
// Far-side controller clocking the flags
// ----------------------------------------
module flag_controller (
  input wire logic shift_clk,
  input wire logic primary_level,
  output logic pull_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pull_low = 1'b0;
  task automatic hold_link(input int n);
    repeat (n) @(posedge shift_clk);
    #1;
  endtask
  // Ten falls for the bits, an eleventh to clear
  task automatic read_word(output logic [9:0] word);
    word = '0;
    for (int i = 0; i <= 10; i++) begin
      pull_low = 1'b1;
      hold_link(5);
      if (i < 10) word[i] = primary_level;
      pull_low = 1'b0;
      hold_link(2);
    end
  endtask
endmodule // flag_controller

// ---- test/tb_short_fault_readout.sv ----
module tb_short_fault_readout;
  import short_fault_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, shift_clk = 1'b0, lk_en = 1'b0, sys_rst = 1'b1, fault_stop_mode = 1'b0;
  fet_sense_t fs = '0;
  supply_status_t sup = '0;
  logic pull_low, oe1, oe2, gate_disable;
  logic [9:0] fcr, w;
  int fail_count = 0, cmp_count = 0;
  wire secondary = ~(oe2 | pull_low);
  wire primary = ~oe1;
  always #20 clk = ~clk;
  always #80 shift_clk = lk_en ? ~shift_clk : 1'b0;
  short_fault_readout dut (.clk(clk), .sys_rst(sys_rst), .shift_clk(shift_clk),
    .fault_stop_mode(fault_stop_mode), .fet_sense(fs), .supply(sup),
    .flag_secondary_in(secondary), .fault_flag_primary_out(), .fault_flag_primary_oe(oe1),
    .fault_flag_secondary_out(), .fault_flag_secondary_oe(oe2),
    .gate_disable(gate_disable), .fault_capture_register(fcr));
  flag_controller ctl (.shift_clk(shift_clk), .primary_level(primary), .pull_low(pull_low));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    fs = '0;
    sup = '0;
    step(8);
    sys_rst = 1'b0;
    step(4);
  endtask
  task automatic readout();
    lk_en = 1'b1;
    ctl.hold_link(3);
    ctl.read_word(w);
    lk_en = 1'b0;
    step(8);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_latch();
    do_reset();
    check("idle flags", 2'b11, {oe1, oe2});
    check("reset fcr", 10'h000, fcr);
    fault_stop_mode = 1'b1;
    fs.high_on[0] = 1'b1;
    fs.high_over[0] = 1'b1;
    fs.low_over[2] = 1'b1;
    step(20);
    check("blank fcr", 10'h000, fcr);
    step(50);
    check("high a fcr", 10'h001, fcr);
    check("short flags", 2'b10, {oe1, oe2});
    check("gate off", 1'b1, gate_disable);
    fs = '0;
    step(6);
    check("latched flags", 2'b10, {oe1, oe2});
    readout();
    check("word", 10'h001, w);
    check("cleared fcr", 10'h000, fcr);
    check("cleared flags", 2'b11, {oe1, oe2});
    $display("test latch done");
  endtask
  task automatic t_live();
    do_reset();
    fault_stop_mode = 1'b0;
    fs.low_on[0] = 1'b1;
    step(60);
    fs.low_over[0] = 1'b1;
    step(6);
    check("live flags", 2'b10, {oe1, oe2});
    check("gate on", 1'b0, gate_disable);
    fs.low_over[0] = 1'b0;
    fs.low_on[0] = 1'b0;
    step(6);
    check("gone flags", 2'b11, {oe1, oe2});
    check("low a fcr", 10'h008, fcr);
    do_reset();
    check("rst fcr", 10'h000, fcr);
    $display("test live done");
  endtask
  task automatic t_order();
    do_reset();
    fs.low_on[2] = 1'b1;
    fs.high_on[1] = 1'b1;
    step(60);
    fs.low_over[2] = 1'b1;
    fs.high_over[1] = 1'b1;
    sup.boot_uv[2] = 1'b1;
    step(4);
    fs = '0;
    sup = '0;
    step(6);
    check("boot flags", 2'b00, {oe1, oe2});
    readout();
    check("word", 10'h222, w);
    sup.vreg_uv = 1'b1;
    step(6);
    check("gate uv fcr", 10'h040, fcr);
    readout();
    check("gate uv word", 10'h040, w);
    check("again flags", 2'b00, {oe1, oe2});
    sup.vreg_uv = 1'b0;
    step(6);
    check("gate uv held", 10'h040, fcr);
    $display("test order done");
  endtask
  task automatic t_supply();
    do_reset();
    fault_stop_mode = 1'b1;
    fs.high_on[2] = 1'b1;
    step(60);
    fs.high_over[2] = 1'b1;
    step(6);
    sup.overtemp = 1'b1;
    step(6);
    check("or flags", 2'b00, {oe1, oe2});
    sup.overtemp = 1'b0;
    sup.vdd_uv = 1'b1;
    step(6);
    check("vdd fcr", 10'h000, fcr);
    check("vdd flags", 2'b00, {oe1, oe2});
    fs = '0;
    sup.vdd_uv = 1'b0;
    sup.overtemp = 1'b1;
    step(6);
    check("ot flags", 2'b01, {oe1, oe2});
    readout();
    check("refused", 2'b01, {oe1, oe2});
    sup.overtemp = 1'b0;
    step(6);
    check("ot gone", 2'b11, {oe1, oe2});
    $display("test supply done");
  endtask
  initial begin
    #400us;
    fail_count++;
    summarize();
  end
  initial begin
    t_latch();
    t_live();
    t_order();
    t_supply();
    summarize();
  end
endmodule // tb_short_fault_readout
